// ---- fpx_regs.vh ----
/*
  Constants for the invalid-operand and denormal-operand exception unit:
  status and control word bit positions, operation codes, operand classes,
  and the default response encodings.
  Assumes it is included by its bare name from the design files.
*/
`ifndef FPX_REGS_VH
`define FPX_REGS_VH

// ****************************************************************
// status and control word bits
// ****************************************************************
`define SW_INVALID_BIT   0
`define SW_DENORMAL_BIT  1
`define CW_INVALID_BIT   0
`define CW_DENORMAL_BIT  1
`define SW_RESET         16'h0000
`define CW_RESET         16'h037f

// ****************************************************************
// operation codes
// ****************************************************************
`define OP_W             5
`define OP_NONE          5'h00
`define OP_ADD           5'h01
`define OP_SUB           5'h02
`define OP_MUL           5'h03
`define OP_DIV           5'h04
`define OP_PREM          5'h05
`define OP_PREM_IEEE     5'h06
`define OP_COS           5'h07
`define OP_PTAN          5'h08
`define OP_SIN           5'h09
`define OP_SINCOS        5'h0a
`define OP_SQRT          5'h0b
`define OP_YL2X          5'h0c
`define OP_YL2XP1        5'h0d
`define OP_BCD_STORE     5'h0e
`define OP_INT_STORE     5'h0f
`define OP_XCHG          5'h10
`define OP_COMPARE       5'h11
`define OP_COMPARE_INT   5'h12
`define OP_UCOMPARE      5'h13
`define OP_LOAD_SD       5'h14
`define OP_LOAD_EXT      5'h15
`define OP_ARITH_OTHER   5'h16

// ****************************************************************
// operand classes
// ****************************************************************
`define CLS_W            3
`define CLS_ZERO         3'h0
`define CLS_NORMAL       3'h1
`define CLS_DENORMAL     3'h2
`define CLS_INF          3'h3
`define CLS_QNAN         3'h4
`define CLS_SNAN         3'h5
`define CLS_UNSUP        3'h6
`define CLS_EMPTY        3'h7

// ****************************************************************
// default responses
// ****************************************************************
`define RSP_W            3
`define RSP_NONE         3'h0
`define RSP_FP_INDEF     3'h1
`define RSP_QUIET_SRC    3'h2
`define RSP_INT_INDEF    3'h3
`define RSP_BCD_INDEF    3'h4
`define RSP_UNORDERED    3'h5
`define RSP_XCHG_FILL    3'h6

`endif

// ---- fpx_classify.v ----
/*
  Classifies one double extended-precision operand (80 bits) into zero,
  normal, denormal, infinity, quiet NaN, signaling NaN or unsupported.
  Assumes an empty tag from the register stack overrides the value.
*/
`timescale 1ns/1ps
`include "fpx_regs.vh"

module fpx_classify (
  // operand
  input  wire [79:0]         value,
  input  wire                empty,
  // class
  output reg  [`CLS_W-1:0]   cls
);

  wire [14:0] expo = value[78:64];
  wire        jbit = value[63];
  wire [62:0] frac = value[62:0];

  always @* begin
    cls = `CLS_NORMAL;
    if (empty) begin
      cls = `CLS_EMPTY;
    end else if (expo == 15'h7fff) begin
      if (!jbit)
        cls = `CLS_UNSUP;
      else if (frac == 63'h0)
        cls = `CLS_INF;
      else if (frac[62])
        cls = `CLS_QNAN;
      else
        cls = `CLS_SNAN;
    end else if (expo == 15'h0000) begin
      // pseudo-denormals are treated as denormals here
      cls = (jbit || frac != 63'h0) ? `CLS_DENORMAL : `CLS_ZERO;
    end else if (!jbit) begin
      cls = `CLS_UNSUP;
    end
  end

endmodule // fpx_classify

// ---- fpx_range_check.v ----
/*
  Decides whether an operand, truncated toward zero, fits a signed integer
  of a given width or 18 packed decimal digits; also compares against -1.
  Assumes a finite, classified operand, or infinity for the -1 compare; callers mask the other classes.
*/
`timescale 1ns/1ps

module fpx_range_check (
  // operand
  input  wire [79:0] value,
  input  wire [1:0]  int_size,
  // results
  output reg         int_over,
  output reg         bcd_over,
  output reg         below_minus_one
);

  wire [14:0] expo = value[78:64];
  wire        sign = value[79];
  // unbiased exponent of a normal value is expo - 16383
  localparam [14:0] BIAS = 15'h3fff;

  function over_pow2;
    input [14:0] e;
    input [6:0]  bits;
    begin
      over_pow2 = (e >= BIAS + {8'h00, bits});
    end
  endfunction

  reg [6:0] width;

  always @* begin
    width = 7'h0f;
    case (int_size)
      2'h0:    width = 7'h0f;
      2'h1:    width = 7'h1f;
      default: width = 7'h3f;
    endcase
    // the exact lower bound (-2^n) is accepted only as a power of two
    int_over = over_pow2(expo, width) &&
               !(sign && expo == BIAS + {8'h00, width} && value[62:0] == 63'h0);
    // 10^18 lies just below 2^60; at exponent 59 the truncated value fits while the significand is below 10^18 << 4
    bcd_over = (expo > BIAS + 15'h003b) ||
               (expo == BIAS + 15'h003b && value[63:0] >= 64'hde0b6b3a76400000);
    below_minus_one = sign && ((expo > BIAS) || (expo == BIAS && value[62:0] != 63'h0));
  end

endmodule // fpx_range_check

// ---- fpx_exc_unit.v ----
/*
  Invalid arithmetic operand and denormal operand detection and response.
  One request per cycle: classifies the operands, sets the sticky status
  bits, picks the masked default response or raises a handler request.
  Assumes the datapath holds the operands steady in the request cycle and
  obeys the result-write gate and stack-pointer hold.
*/
`timescale 1ns/1ps
`include "fpx_regs.vh"

module fpx_exc_unit (
  // clock and reset
  input  wire                MCLK,
  input  wire                ARST_N,
  // request from the datapath
  input  wire                REQ_VALID,
  input  wire [`OP_W-1:0]    OP_CODE,
  input  wire [79:0]         OPND_A,
  input  wire [79:0]         OPND_B,
  input  wire                EMPTY_A,
  input  wire                EMPTY_B,
  input  wire [1:0]          INT_SIZE,
  // control word and status clear
  input  wire [15:0]         CONTROL_WORD,
  input  wire                CLEAR_FLAGS,
  // status
  output reg                 INVALID_OP_FLAG,
  output reg                 DENORMAL_FLAG,
  // response to the datapath
  output reg                 RSP_VALID,
  output reg  [`RSP_W-1:0]   RSP_KIND,
  output reg  [79:0]         RSP_VALUE,
  output reg                 RSP_FILL_A,
  output reg                 RSP_FILL_B,
  output reg                 RESULT_WRITE_EN,
  output reg                 SET_CC_UNORDERED,
  output reg                 CLEAR_C2,
  output reg                 NORMALIZE_LOAD,
  output reg                 HOLD_STACK,
  output reg                 HANDLER_REQ
);

  // ****************************************************************
  // default values
  // ****************************************************************
  localparam [79:0] FP_INDEF  = 80'hffff_c000_0000_0000_0000;
  localparam [79:0] INT_INDEF = 80'h0000_8000_0000_0000_0000;
  localparam [79:0] BCD_INDEF = 80'hffff_c000_0000_0000_0000;

  // ****************************************************************
  // operand classification
  // ****************************************************************
  wire [`CLS_W-1:0] cls_a;
  wire [`CLS_W-1:0] cls_b;
  wire              int_over;
  wire              bcd_over;
  wire              below_m1;

  fpx_classify u_cls_a (
    .value (OPND_A),
    .empty (EMPTY_A),
    .cls   (cls_a)
  );

  fpx_classify u_cls_b (
    .value (OPND_B),
    .empty (EMPTY_B),
    .cls   (cls_b)
  );

  fpx_range_check u_range (
    .value           (OPND_A),
    .int_size        (INT_SIZE),
    .int_over        (int_over),
    .bcd_over        (bcd_over),
    .below_minus_one (below_m1)
  );

  function is_nan;
    input [`CLS_W-1:0] c;
    begin
      is_nan = (c == `CLS_QNAN) || (c == `CLS_SNAN);
    end
  endfunction

  function is_special;
    input [`CLS_W-1:0] c;
    begin
      is_special = is_nan(c) || (c == `CLS_INF) || (c == `CLS_UNSUP);
    end
  endfunction

  // ****************************************************************
  // operation groups
  // ****************************************************************
  wire op_two   = (OP_CODE == `OP_ADD) || (OP_CODE == `OP_SUB) || (OP_CODE == `OP_MUL) ||
                  (OP_CODE == `OP_DIV) || (OP_CODE == `OP_PREM) || (OP_CODE == `OP_PREM_IEEE) ||
                  (OP_CODE == `OP_YL2X) || (OP_CODE == `OP_YL2XP1) || (OP_CODE == `OP_COMPARE) ||
                  (OP_CODE == `OP_COMPARE_INT) || (OP_CODE == `OP_UCOMPARE);
  wire op_prem  = (OP_CODE == `OP_PREM) || (OP_CODE == `OP_PREM_IEEE);
  wire op_trig  = (OP_CODE == `OP_COS) || (OP_CODE == `OP_PTAN) ||
                  (OP_CODE == `OP_SIN) || (OP_CODE == `OP_SINCOS);
  wire op_cmp   = (OP_CODE == `OP_COMPARE) || (OP_CODE == `OP_COMPARE_INT);
  wire op_ucmp  = (OP_CODE == `OP_UCOMPARE);
  wire op_store = (OP_CODE == `OP_BCD_STORE) || (OP_CODE == `OP_INT_STORE);
  wire op_load  = (OP_CODE == `OP_LOAD_SD) || (OP_CODE == `OP_LOAD_EXT);
  wire op_xchg  = (OP_CODE == `OP_XCHG);
  wire op_arith = (OP_CODE != `OP_NONE) && !op_xchg && !op_load;

  wire sign_a = OPND_A[79];
  wire sign_b = OPND_B[79];

  // ****************************************************************
  // detection and default response
  // ****************************************************************
  reg              inv;
  reg              den;
  reg [`RSP_W-1:0] kind;
  reg [79:0]       value;
  reg              cc_unord;
  reg              c2_clr;
  reg              unsup_any;
  reg              snan_any;
  reg              qnan_any;

  always @* begin
    inv       = 1'b0;
    den       = 1'b0;
    kind      = `RSP_NONE;
    value     = FP_INDEF;
    cc_unord  = 1'b0;
    c2_clr    = 1'b0;
    unsup_any = (cls_a == `CLS_UNSUP) || (op_two && cls_b == `CLS_UNSUP);
    snan_any  = (cls_a == `CLS_SNAN) || (op_two && cls_b == `CLS_SNAN);
    qnan_any  = (cls_a == `CLS_QNAN) || (op_two && cls_b == `CLS_QNAN);
    if (op_arith && !op_store) begin
      if (unsup_any) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end else if (snan_any) begin
        inv  = 1'b1;
        kind = `RSP_QUIET_SRC;
        value = (cls_a == `CLS_SNAN) ? {OPND_A[79:63], 1'b1, OPND_A[61:0]}
                                     : {OPND_B[79:63], 1'b1, OPND_B[61:0]};
      end else if (op_cmp && qnan_any) begin
        inv      = 1'b1;
        kind     = `RSP_UNORDERED;
        cc_unord = 1'b1;
      end else if (qnan_any) begin
        inv = 1'b0;
      end else if (OP_CODE == `OP_ADD && cls_a == `CLS_INF && cls_b == `CLS_INF && sign_a != sign_b) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end else if (OP_CODE == `OP_SUB && cls_a == `CLS_INF && cls_b == `CLS_INF && sign_a == sign_b) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end else if (OP_CODE == `OP_MUL && ((cls_a == `CLS_INF && cls_b == `CLS_ZERO) ||
                                          (cls_a == `CLS_ZERO && cls_b == `CLS_INF))) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end else if (OP_CODE == `OP_DIV && ((cls_a == `CLS_INF && cls_b == `CLS_INF) ||
                                          (cls_a == `CLS_ZERO && cls_b == `CLS_ZERO))) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end else if (op_prem && (cls_b == `CLS_ZERO || cls_a == `CLS_INF)) begin
        inv    = 1'b1;
        kind   = `RSP_FP_INDEF;
        c2_clr = 1'b1;
      end else if (op_trig && cls_a == `CLS_INF) begin
        inv    = 1'b1;
        kind   = `RSP_FP_INDEF;
        c2_clr = 1'b1;
      end else if ((OP_CODE == `OP_SQRT || OP_CODE == `OP_YL2X) && sign_a && cls_a != `CLS_ZERO) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end else if (OP_CODE == `OP_YL2XP1 && (cls_a == `CLS_NORMAL || cls_a == `CLS_INF) && below_m1) begin
        inv  = 1'b1;
        kind = `RSP_FP_INDEF;
      end
    end
    if (op_ucmp && !unsup_any && !snan_any) begin
      inv      = 1'b0;
      cc_unord = 1'b0;
    end
    if (OP_CODE == `OP_BCD_STORE && (is_special(cls_a) || (cls_a == `CLS_NORMAL && bcd_over))) begin
      inv   = 1'b1;
      kind  = `RSP_BCD_INDEF;
      value = BCD_INDEF;
    end
    if (OP_CODE == `OP_INT_STORE && (is_special(cls_a) || (cls_a == `CLS_NORMAL && int_over))) begin
      inv   = 1'b1;
      kind  = `RSP_INT_INDEF;
      value = INT_INDEF;
    end
    if (op_xchg && (cls_a == `CLS_EMPTY || cls_b == `CLS_EMPTY)) begin
      inv  = 1'b1;
      kind = `RSP_XCHG_FILL;
    end
    // denormals flag even when invalid also fires; the caller prioritises
    if (op_arith && (cls_a == `CLS_DENORMAL || (op_two && cls_b == `CLS_DENORMAL)))
      den = 1'b1;
    if (OP_CODE == `OP_LOAD_SD && cls_a == `CLS_DENORMAL)
      den = 1'b1;
  end

  // ****************************************************************
  // masks and handler request
  // ****************************************************************
  wire inv_masked = CONTROL_WORD[`CW_INVALID_BIT];
  wire den_masked = CONTROL_WORD[`CW_DENORMAL_BIT];
  wire inv_hit    = REQ_VALID && inv;
  wire den_hit    = REQ_VALID && den;
  // unmasked traps win over any default response for the instruction
  wire trap       = (inv_hit && !inv_masked) || (den_hit && !den_masked);

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      INVALID_OP_FLAG  <= 1'b0;
      DENORMAL_FLAG    <= 1'b0;
      RSP_VALID        <= 1'b0;
      RSP_KIND         <= `RSP_NONE;
      RSP_VALUE        <= 80'h0;
      RSP_FILL_A       <= 1'b0;
      RSP_FILL_B       <= 1'b0;
      RESULT_WRITE_EN  <= 1'b0;
      SET_CC_UNORDERED <= 1'b0;
      CLEAR_C2         <= 1'b0;
      NORMALIZE_LOAD   <= 1'b0;
      HOLD_STACK       <= 1'b0;
      HANDLER_REQ      <= 1'b0;
    end else begin
      // a new event in the clearing cycle keeps its flag set
      if (inv_hit)
        INVALID_OP_FLAG <= 1'b1;
      else if (CLEAR_FLAGS)
        INVALID_OP_FLAG <= 1'b0;
      if (den_hit)
        DENORMAL_FLAG <= 1'b1;
      else if (CLEAR_FLAGS)
        DENORMAL_FLAG <= 1'b0;
      RSP_VALID        <= REQ_VALID;
      RSP_KIND         <= (inv_hit && inv_masked && !trap) ? kind : `RSP_NONE;
      RSP_VALUE        <= value;
      RSP_FILL_A       <= inv_hit && inv_masked && !trap && op_xchg && cls_a == `CLS_EMPTY;
      RSP_FILL_B       <= inv_hit && inv_masked && !trap && op_xchg && cls_b == `CLS_EMPTY;
      RESULT_WRITE_EN  <= REQ_VALID && !trap && !(inv_hit && kind == `RSP_UNORDERED);
      SET_CC_UNORDERED <= inv_hit && inv_masked && !trap && cc_unord;
      CLEAR_C2         <= inv_hit && inv_masked && !trap && c2_clr;
      NORMALIZE_LOAD   <= den_hit && den_masked && !trap;
      HOLD_STACK       <= trap;
      HANDLER_REQ      <= trap;
    end
  end

endmodule // fpx_exc_unit

// ---- fpx_exc_props.sv ----
/*
  Concurrent checks on the ports of the exception unit, bound to it below.
  Assumes one clock domain and a response one cycle after each request.
*/
`timescale 1ns/1ps
`include "fpx_regs.vh"

module fpx_exc_checker (
  // clock and reset
  input logic        MCLK,
  input logic        ARST_N,
  // request
  input logic        REQ_VALID,
  input logic [4:0]  OP_CODE,
  input logic [79:0] OPND_A,
  input logic [79:0] OPND_B,
  input logic [15:0] CONTROL_WORD,
  input logic        CLEAR_FLAGS,
  // response
  input logic        INVALID_OP_FLAG,
  input logic        DENORMAL_FLAG,
  input logic        RSP_VALID,
  input logic [2:0]  RSP_KIND,
  input logic        RESULT_WRITE_EN,
  input logic        SET_CC_UNORDERED,
  input logic        CLEAR_C2,
  input logic        NORMALIZE_LOAD,
  input logic        HOLD_STACK,
  input logic        HANDLER_REQ
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!ARST_N);

  a_rsp_one_cycle: assert property (REQ_VALID |=> RSP_VALID) else $error("response missing");
  a_trap_holds_stack: assert property (HANDLER_REQ |-> HOLD_STACK && !RESULT_WRITE_EN && RSP_KIND == `RSP_NONE)
    else $error("trap without stack hold");
  a_masked_no_trap: assert property (REQ_VALID && CONTROL_WORD[1:0] == 2'b11 |=> !HANDLER_REQ)
    else $error("trap while masked");
  a_flag_sticky: assert property (INVALID_OP_FLAG && !CLEAR_FLAGS |=> INVALID_OP_FLAG) else $error("flag lost");
  a_flag_clear: assert property (CLEAR_FLAGS && !REQ_VALID |=> !INVALID_OP_FLAG && !DENORMAL_FLAG)
    else $error("flags not cleared");
  a_flag_cause: assert property ($rose(INVALID_OP_FLAG) || $rose(DENORMAL_FLAG) |-> $past(REQ_VALID))
    else $error("flag without request");
  a_denorm_load: assert property (REQ_VALID && OP_CODE == `OP_LOAD_SD && OPND_A[78:64] == 15'h0 &&
    OPND_A[63:0] != 64'h0 |=> DENORMAL_FLAG && NORMALIZE_LOAD == $past(CONTROL_WORD[1]) &&
    HANDLER_REQ != $past(CONTROL_WORD[1])) else $error("denormal load response wrong");
  a_ext_load_quiet: assert property (REQ_VALID && OP_CODE == `OP_LOAD_EXT |=> !HANDLER_REQ && !NORMALIZE_LOAD)
    else $error("extended load signalled");
  a_cmp_unordered: assert property (REQ_VALID && CONTROL_WORD[1:0] == 2'b11 && OP_CODE == `OP_COMPARE &&
    OPND_A[78:62] == 17'h1ffff && OPND_B[78:64] != 15'h7fff && OPND_B[63]
    |=> SET_CC_UNORDERED && INVALID_OP_FLAG) else $error("compare codes not set");
  a_trig_inf: assert property (REQ_VALID && CONTROL_WORD[1:0] == 2'b11 && OP_CODE == `OP_COS &&
    OPND_A[78:0] == {15'h7fff, 64'h8000000000000000} |=> CLEAR_C2 && RSP_KIND == `RSP_FP_INDEF)
    else $error("trig default wrong");
  a_set_over_clear: assert property (REQ_VALID && CLEAR_FLAGS && CONTROL_WORD[1:0] == 2'b11 &&
    OP_CODE == `OP_LOAD_SD && OPND_A[78:64] == 15'h0 && OPND_A[63:0] != 64'h0 |=> DENORMAL_FLAG)
    else $error("clear beat a new denormal");

  c_trap: cover property (HANDLER_REQ);
  c_unordered: cover property (SET_CC_UNORDERED);
  c_normalize: cover property (NORMALIZE_LOAD);
endmodule // fpx_exc_checker

bind fpx_exc_unit fpx_exc_checker chk (.MCLK(MCLK), .ARST_N(ARST_N), .REQ_VALID(REQ_VALID), .OP_CODE(OP_CODE),
  .OPND_A(OPND_A), .OPND_B(OPND_B), .CONTROL_WORD(CONTROL_WORD), .CLEAR_FLAGS(CLEAR_FLAGS),
  .INVALID_OP_FLAG(INVALID_OP_FLAG), .DENORMAL_FLAG(DENORMAL_FLAG), .RSP_VALID(RSP_VALID), .RSP_KIND(RSP_KIND),
  .RESULT_WRITE_EN(RESULT_WRITE_EN), .SET_CC_UNORDERED(SET_CC_UNORDERED), .CLEAR_C2(CLEAR_C2),
  .NORMALIZE_LOAD(NORMALIZE_LOAD), .HOLD_STACK(HOLD_STACK), .HANDLER_REQ(HANDLER_REQ));

// ---- fpx_datapath_model.sv ----
/*
  Datapath stand-in: keeps a stack pointer that a result write pushes.
  Assumes it samples the unit's registered response at each rising edge.
*/
`timescale 1ns/1ps

module fpx_datapath_model (
  // clock and reset
  input  logic       clk,
  input  logic       rst_n,
  // response from the unit
  input  logic       rsp_valid,
  input  logic       write_en,
  input  logic       hold_stack,
  // state
  output logic [2:0] top_reg
);
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      top_reg <= 3'h0;
    else if (rsp_valid && write_en && !hold_stack)
      top_reg <= top_reg + 3'h1;
  end
endmodule // fpx_datapath_model

// ---- fpx_invalid_denormal_exc_bench.sv ----
/*
  Self-checking bench: directed corner cases, then random arithmetic.
  Assumes the one-cycle response and sticky flags of the unit.
*/
`timescale 1ns/1ps
`include "fpx_regs.vh"
`define CHK(n, e, g) begin cmp_count++; if ((g) !== (e)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", n, e, g); end end

module fpx_invalid_denormal_exc_bench;
  localparam [79:0] PINF = 80'h7fff8000000000000000, ONE = 80'h3fff8000000000000000;
  localparam [79:0] QNAN = 80'h7fffc000000000000000, SNAN = 80'h7fffa000000000000000;
  localparam [79:0] DEN = 80'h00000000000000000001, INDEF = 80'hffffc000000000000000;
  reg         mclk = 0, arst_n = 0, req = 0, ea = 0, eb = 0, clr = 0;
  reg  [4:0]  op = 0;
  reg  [79:0] a = 0, b = 0;
  reg  [1:0]  sz = 0;
  reg  [15:0] cw = 16'h037f;
  wire        inv, den, rv, fa, fb, wen, cc, c2, nrm, hold, trap;
  wire [2:0]  kind, top;
  wire [79:0] val;
  reg  [79:0] tbl [0:9];
  reg  [5:0]  e;
  reg  [2:0]  t0;
  int         fails = 0, cmp_count = 0, i;

  fpx_exc_unit uut (.MCLK(mclk), .ARST_N(arst_n), .REQ_VALID(req), .OP_CODE(op), .OPND_A(a), .OPND_B(b),
    .EMPTY_A(ea), .EMPTY_B(eb), .INT_SIZE(sz), .CONTROL_WORD(cw), .CLEAR_FLAGS(clr), .INVALID_OP_FLAG(inv),
    .DENORMAL_FLAG(den), .RSP_VALID(rv), .RSP_KIND(kind), .RSP_VALUE(val), .RSP_FILL_A(fa), .RSP_FILL_B(fb),
    .RESULT_WRITE_EN(wen), .SET_CC_UNORDERED(cc), .CLEAR_C2(c2), .NORMALIZE_LOAD(nrm), .HOLD_STACK(hold),
    .HANDLER_REQ(trap));
  fpx_datapath_model dp (.clk(mclk), .rst_n(arst_n), .rsp_valid(rv), .write_en(wen), .hold_stack(hold),
    .top_reg(top));

  always #5 mclk = ~mclk;

  function [2:0] cls(input [79:0] v);
    if (v[78:64] == 15'h7fff)
      cls = !v[63] ? `CLS_UNSUP : v[62:0] == 0 ? `CLS_INF : v[62] ? `CLS_QNAN : `CLS_SNAN;
    else if (v[78:64] == 15'h0)
      cls = v[63:0] == 0 ? `CLS_ZERO : `CLS_DENORMAL;
    else
      cls = v[63] ? `CLS_NORMAL : `CLS_UNSUP;
  endfunction

  // {invalid, denormal, trap, kind} for the add, subtract, multiply and divide codes
  function [5:0] ref_arith(input [4:0] o, input [79:0] x, y, input [1:0] m);
    reg [2:0] p, q, k;
    reg iv, dn, tr;
    p = cls(x);
    q = cls(y);
    iv = p == `CLS_UNSUP || q == `CLS_UNSUP || p == `CLS_SNAN || q == `CLS_SNAN;
    k = (p == `CLS_UNSUP || q == `CLS_UNSUP || !iv) ? `RSP_FP_INDEF : `RSP_QUIET_SRC;
    if (!iv && p != `CLS_QNAN && q != `CLS_QNAN)
      case (o)
        `OP_ADD: iv = p == `CLS_INF && q == `CLS_INF && x[79] != y[79];
        `OP_SUB: iv = p == `CLS_INF && q == `CLS_INF && x[79] == y[79];
        `OP_MUL: iv = (p == `CLS_INF && q == `CLS_ZERO) || (p == `CLS_ZERO && q == `CLS_INF);
        default: iv = (p == `CLS_INF && q == `CLS_INF) || (p == `CLS_ZERO && q == `CLS_ZERO);
      endcase
    dn = p == `CLS_DENORMAL || q == `CLS_DENORMAL;
    tr = (iv && !m[0]) || (dn && !m[1]);
    ref_arith = {iv, dn, tr, tr ? `RSP_NONE : iv ? k : `RSP_NONE};
  endfunction

  task test_done;
    if (fails == 0 && cmp_count > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // clears the flags, then one request; returns at the falling edge where the answer stands
  task dir(input [4:0] o, input [79:0] x, y, input [15:0] c, input [1:0] s, input [5:0] ex);
    clr = 1;
    @(negedge mclk);
    clr = 0;
    {op, a, b, cw, sz, req} = {o, x, y, c, s, 1'b1};
    @(negedge mclk);
    req = 0;
    `CHK("rsp_valid", 1'b1, rv)
    `CHK("invalid", ex[5], inv)
    `CHK("denormal", ex[4], den)
    `CHK("handler", ex[3], trap)
    `CHK("hold", ex[3], hold)
    `CHK("kind", ex[2:0], kind)
    `CHK("write", !ex[3] && ex[2:0] != `RSP_UNORDERED, wen)
    if (ex[2:0] == `RSP_FP_INDEF)
      `CHK("value", INDEF, val)
  endtask

  initial begin
    #200000;
    fails++;
    test_done;
  end

  initial begin
    tbl = '{80'h0, 80'h8000_0000000000000000, ONE, 80'hbfff8000000000000000, PINF, 80'hffff8000000000000000,
      QNAN, SNAN, DEN, 80'h3fff0000000000000001};
    void'($urandom(32'h0870));
    repeat (2) @(negedge mclk);
    arst_n = 1;
    dir(`OP_ADD, PINF, tbl[5], 16'h037f, 0, {3'b100, `RSP_FP_INDEF});
    t0 = top;
    dir(`OP_ADD, PINF, tbl[5], 16'h037e, 0, {3'b101, `RSP_NONE});
    @(negedge mclk);
    `CHK("top", t0 + 3'h1, top)
    dir(`OP_SUB, PINF, PINF, 16'h037f, 0, {3'b100, `RSP_FP_INDEF});
    dir(`OP_ADD, SNAN, ONE, 16'h037f, 0, {3'b100, `RSP_QUIET_SRC});
    `CHK("quiet", 80'h7fffe000000000000000, val)
    for (i = 0; i < 2; i++) begin
      dir(i ? `OP_COMPARE_INT : `OP_COMPARE, QNAN, ONE, 16'h037f, 0, {3'b100, `RSP_UNORDERED});
      `CHK("unordered", 1'b1, cc)
    end
    dir(`OP_UCOMPARE, QNAN, ONE, 16'h037f, 0, 6'h0);
    for (i = 0; i < 6; i++) begin
      dir(5'(i < 2 ? `OP_PREM + i : `OP_COS + i - 2), i < 2 ? ONE : PINF, 80'h0, 16'h037f, 0, 6'h21);
      `CHK("clear_c2", 1'b1, c2)
    end
    dir(`OP_SQRT, tbl[3], 0, 16'h037f, 0, 6'h21);
    dir(`OP_SQRT, tbl[1], 0, 16'h037f, 0, 6'h0);
    dir(`OP_YL2X, tbl[3], ONE, 16'h037f, 0, 6'h21);
    dir(`OP_YL2XP1, 80'hc0008000000000000000, ONE, 16'h037f, 0, 6'h21);
    dir(`OP_YL2XP1, 80'hbffe8000000000000000, ONE, 16'h037f, 0, 6'h0);
    dir(`OP_BCD_STORE, QNAN, 0, 16'h037f, 0, {3'b100, `RSP_BCD_INDEF});
    `CHK("bcd", INDEF, val)
    dir(`OP_BCD_STORE, 80'h403e8000000000000000, 0, 16'h037f, 0, {3'b100, `RSP_BCD_INDEF});
    dir(`OP_BCD_STORE, 80'h403ade0b6b3a763ffff0, 0, 16'h037f, 0, 6'h0);
    dir(`OP_BCD_STORE, 80'h403ade0b6b3a76400000, 0, 16'h037f, 0, {3'b100, `RSP_BCD_INDEF});
    dir(`OP_INT_STORE, 80'h40138000000000000000, 0, 16'h037f, 0, {3'b100, `RSP_INT_INDEF});
    `CHK("int_msb", 1'b1, val[63])
    dir(`OP_INT_STORE, 80'h40138000000000000000, 0, 16'h037f, 1, 6'h0);
    ea = 1;
    dir(`OP_XCHG, ONE, ONE, 16'h037f, 0, {3'b100, `RSP_XCHG_FILL});
    `CHK("fill", 2'b10, {fa, fb})
    ea = 0;
    dir(`OP_LOAD_SD, DEN, 0, 16'h037f, 0, 6'h10);
    `CHK("normalize", 1'b1, nrm)
    dir(`OP_LOAD_SD, DEN, 0, 16'h037d, 0, 6'h18);
    dir(`OP_LOAD_EXT, DEN, 0, 16'h037d, 0, 6'h0);
    // clear and a new denormal in one cycle: the new event must keep its flag
    @(negedge mclk);
    {op, a, cw, clr, req} = {`OP_LOAD_SD, DEN, 16'h037f, 1'b1, 1'b1};
    @(negedge mclk);
    req = 0;
    `CHK("set_wins", 2'b11, {den, nrm})
    dir(`OP_ARITH_OTHER, 80'h3fff0000000000000001, 0, 16'h037f, 0, 6'h21);
    for (i = 0; i < 300; i++) begin
      {op, a, b} = {5'h1 + 5'($urandom % 4), tbl[$urandom % 10], tbl[$urandom % 10]};
      cw = 16'($urandom);
      e = ref_arith(op, a, b, cw[1:0]);
      dir(op, a, b, cw, 0, e);
      `CHK("codes", {2'b00, e[4] && cw[1] && !e[3]}, {cc, c2, nrm})
    end
    arst_n = 0;
    #3;
    `CHK("reset", 3'h0, {inv, den, rv})
    test_done;
  end
endmodule // fpx_invalid_denormal_exc_bench
